// ==== design/status_display_map.svh ====
// register offsets, field positions, segment patterns and timing figures of the status display
`ifndef STATUS_DISPLAY_MAP_SVH
`define STATUS_DISPLAY_MAP_SVH
// register byte offsets
`define REG_CTRL_ADDR 12'h000
`define REG_MODE_ADDR 12'h004
`define REG_RECORD_ADDR 12'h008
`define REG_DIAG_ADDR 12'h00C
`define REG_STATUS_ADDR 12'h010
`define REG_MOTION_ADDR 12'h014
// control register fields
`define CTRL_ACK_BIT 0
`define CTRL_BUS_ACK_BIT 1
`define CTRL_FIELDBUS_BIT 2
`define CTRL_RESET_BIT 3
// diag register fields: [7:0] main index, [11:8] sub index, 12 error, 13 warning
`define DIAG_MAIN_LSB 0
`define DIAG_SUB_LSB 8
`define DIAG_ERR_BIT 12
`define DIAG_WARN_BIT 13
// timing, warning repeats, longest character sequence and segment patterns
`define CLK_HZ 20000000
`define STEP_MS 500
`define BLINK_MS 250
`define ENABLE_FILTER_MS 2
`define RESET_PULSE_US 100
`define WARN_REPEATS 2
`define MAX_CHARS 6
`define SEG_BLANK 8'h00
`define SEG_DOT 8'h80
`define SEG_DASH 8'h40
`define SEG_MIDDLE 8'h40
`endif

// ==== design/status_display_pkg.sv ====
// types shared by the status display design
package status_display_pkg;
  typedef enum logic [3:0] {
    MODE_UNPARAM, MODE_FLASH, MODE_BOOT, MODE_CARD_LOAD, MODE_SAFE, MODE_IDENTIFY,
    MODE_SPEED, MODE_TORQUE, MODE_POSITION, MODE_HOMING
  } mode_type;
  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} resp_type;
  typedef logic [7:0] segment_type;
endpackage : status_display_pkg

// ==== design/char_to_segment.sv ====
// character code to seven-segment pattern decoder
module char_to_segment (
  // character in
  input wire logic [4:0] char_i,
  // segments out: bit0 a .. bit6 g, no point bit
  output logic [6:0] seg_o
);
  always_comb begin
    case (char_i)
      5'h00: seg_o = 7'h3F;
      5'h01: seg_o = 7'h06;
      5'h02: seg_o = 7'h5B;
      5'h03: seg_o = 7'h4F;
      5'h04: seg_o = 7'h66;
      5'h05: seg_o = 7'h6D;
      5'h06: seg_o = 7'h7D;
      5'h07: seg_o = 7'h07;
      5'h08: seg_o = 7'h7F;
      5'h09: seg_o = 7'h6F;
      5'h0A: seg_o = 7'h77; // A
      5'h0B: seg_o = 7'h71; // F
      5'h0C: seg_o = 7'h5E; // d
      5'h0D: seg_o = 7'h76; // H
      5'h0E: seg_o = 7'h79; // E
      5'h0F: seg_o = 7'h38; // L
      5'h10: seg_o = 7'h73; // P
      5'h11: seg_o = 7'h06; // I
      5'h12: seg_o = 7'h40; // dash
      default: seg_o = 7'h00;
    endcase
  end
endmodule : char_to_segment

// ==== design/status_display.sv ====
// status display, front lamps and error acknowledgement with an AXI4-Lite register slave
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`include "status_display_map.svh"

// Overview of operation
// RQ1: display shows operating mode, and a coded error number on fault
// RQ2: codes longer than the display are shown one character after another
// RQ3: lamps: green run or red fault, green enable, yellow fieldbus
// RQ4: unparameterised controller shows A
// RQ5: firmware flash writing shows F
// RQ6: boot loader blinks only the decimal point
// RQ7: parameter set loading from card shows d
// RQ8: safe state blinks H, distinct from safe torque off status
// RQ9: identify function shows HELLO
// RQ10: speed mode rotates outer segments following position or speed
// RQ11: speed mode middle bar lit only while enable asserted
// RQ12: positioning shows P and record 000 or 001 to 255
// RQ13: jog 259/260, cam 262, direct manual records 264/265
// RQ14: homing shows PH and phase 0, 1 or 2
// RQ15: error shows E, two-digit main and one-digit sub index
// RQ16: warning shows dash, main, sub, repeated at least twice
// RQ17: acknowledge from interface, fieldbus control word or enable falling edge
// RQ18: warnings clear themselves once their cause is gone
// RQ19: reset button gives a hardware reset pulse to the processor
// RQ20: stage stays off until fault cause gone and error acknowledged
// RQ21: acknowledging edge on enable input also withdraws enable
// RQ22: host holds enable levels about 80 ms so the edge is seen
// RQ23: torque mode shows I
module status_display #(
  parameter int STEP_CYCLES = `CLK_HZ / 1000 * `STEP_MS,
  parameter int BLINK_CYCLES = `CLK_HZ / 1000 * `BLINK_MS,
  parameter int FILTER_CYCLES = `CLK_HZ / 1000 * `ENABLE_FILTER_MS,
  parameter int RESET_CYCLES = `CLK_HZ / 1000000 * `RESET_PULSE_US
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output status_display_pkg::resp_type s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output status_display_pkg::resp_type s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller inputs
  input wire logic enable_ack_input_i,
  input wire logic reset_button_i,
  input wire logic fault_cause_i,
  input wire logic warning_cause_i,
  input wire logic [3:0] speed_phase_i,
  // indicators
  output status_display_pkg::segment_type segments_o,
  output logic run_fault_lamp_green_o,
  output logic run_fault_lamp_red_o,
  output logic enable_lamp_o,
  output logic fieldbus_lamp_o,
  // power stage and processor
  output logic stage_enable_o,
  output logic processor_reset_o
);
  import status_display_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    resp_type bresp;
    logic rvalid;
    logic [31:0] rdata;
    resp_type rresp;
    mode_type mode;
    logic [8:0] record;
    logic [1:0] home_phase;
    logic [7:0] diag_main;
    logic [3:0] diag_sub;
    logic error;
    logic warning;
    logic fieldbus;
    logic en_filt;
    logic [15:0] filt_cnt;
    logic enable;
    logic [23:0] step_cnt;
    logic [23:0] blink_cnt;
    logic blink;
    logic [2:0] char_idx;
    logic [1:0] warn_shown;
    logic [11:0] rst_cnt;
    logic btn_prev;
    logic [7:0] seg;
  } state_type;

  state_type state_reg, state_next;

  // ----------------------------------------------------------------
  // character sequence of the current code
  // ----------------------------------------------------------------
  logic [4:0] chars [`MAX_CHARS];
  logic [2:0] char_count;
  logic [4:0] cur_char;
  logic [6:0] cur_seg;
  logic show_diag;

  function automatic logic [4:0] digit(input logic [9:0] v, input int pos);
    logic [9:0] q;
    q = v;
    for (int i = 0; i < pos; i++) begin
      q = q / 10'd10;
    end
    return 5'(q % 10'd10);
  endfunction : digit

  always_comb begin
    for (int i = 0; i < `MAX_CHARS; i++) begin
      chars[i] = 5'h1F;
    end
    char_count = 3'd1;
    show_diag = state_reg.error || state_reg.warning;
    if (state_reg.error) begin
      chars[0] = 5'h0E; // RQ15
      chars[1] = digit({2'b00, state_reg.diag_main}, 1);
      chars[2] = digit({2'b00, state_reg.diag_main}, 0);
      chars[3] = 5'(state_reg.diag_sub);
      char_count = 3'd4; // RQ1
    end else if (state_reg.warning) begin
      chars[0] = 5'h12; // RQ16
      chars[1] = digit({2'b00, state_reg.diag_main}, 1);
      chars[2] = digit({2'b00, state_reg.diag_main}, 0);
      chars[3] = 5'(state_reg.diag_sub);
      char_count = 3'd4;
    end else begin
      case (state_reg.mode)
        MODE_UNPARAM: chars[0] = 5'h0A; // RQ4
        MODE_FLASH: chars[0] = 5'h0B; // RQ5
        MODE_CARD_LOAD: chars[0] = 5'h0C; // RQ7
        MODE_SAFE: chars[0] = 5'h0D; // RQ8
        MODE_TORQUE: chars[0] = 5'h11; // RQ23
        MODE_IDENTIFY: begin
          chars[0] = 5'h0D; // RQ9
          chars[1] = 5'h0E;
          chars[2] = 5'h0F;
          chars[3] = 5'h0F;
          chars[4] = 5'h00;
          char_count = 3'd5;
        end
        MODE_POSITION: begin
          chars[0] = 5'h10; // RQ12
          chars[1] = digit({1'b0, state_reg.record}, 2); // RQ13
          chars[2] = digit({1'b0, state_reg.record}, 1);
          chars[3] = digit({1'b0, state_reg.record}, 0);
          char_count = 3'd4;
        end
        MODE_HOMING: begin
          chars[0] = 5'h10; // RQ14
          chars[1] = 5'h0D;
          chars[2] = {3'b000, state_reg.home_phase};
          char_count = 3'd3;
        end
        default: chars[0] = 5'h1F;
      endcase
    end
    cur_char = chars[state_reg.char_idx];
  end

  char_to_segment decode_inst (
    .char_i(cur_char),
    .seg_o(cur_seg)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic aw_take, w_take, ar_take, do_write, step_tick, blink_tick;
  logic en_fall, ack, btn_press, set_err, set_warn;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [11:0] wa;
  logic [7:0] rot;

  always_comb begin
    state_next = state_reg;
    aw_take = s_axi_awvalid && !state_reg.aw_full;
    w_take = s_axi_wvalid && !state_reg.w_full;
    ar_take = s_axi_arvalid && !state_reg.rvalid;
    wa = state_reg.aw_full ? state_reg.aw_addr : s_axi_awaddr;
    wd = state_reg.w_full ? state_reg.w_data : s_axi_wdata;
    // lanes travel with their data word, which may arrive before the address
    ws = state_reg.w_full ? state_reg.w_strb : s_axi_wstrb;
    do_write = (state_reg.aw_full || aw_take) && (state_reg.w_full || w_take)
      && !state_reg.bvalid;
    ack = 1'b0;
    set_err = 1'b0;
    set_warn = 1'b0;
    // bus slave: address and data in either order, response after both
    if (aw_take) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      case (wa)
        `REG_CTRL_ADDR: begin
          if (ws[0]) begin
            ack = wd[`CTRL_ACK_BIT] || wd[`CTRL_BUS_ACK_BIT]; // RQ17
            state_next.fieldbus = wd[`CTRL_FIELDBUS_BIT];
          end
        end
        `REG_MODE_ADDR: if (ws[0]) state_next.mode = mode_type'(wd[3:0]);
        `REG_RECORD_ADDR: begin
          if (ws[0]) state_next.record[7:0] = wd[7:0];
          if (ws[1]) state_next.record[8] = wd[8];
          if (ws[2]) state_next.home_phase = wd[17:16];
        end
        `REG_DIAG_ADDR: begin
          if (ws[0]) state_next.diag_main = wd[`DIAG_MAIN_LSB +: 8];
          if (ws[1]) begin
            state_next.diag_sub = wd[`DIAG_SUB_LSB +: 4];
            set_err = wd[`DIAG_ERR_BIT];
            set_warn = wd[`DIAG_WARN_BIT];
          end
        end
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL_ADDR: state_next.rdata = {29'h0, state_reg.fieldbus, 2'b00};
        `REG_MODE_ADDR: state_next.rdata = {28'h0, state_reg.mode};
        `REG_RECORD_ADDR: state_next.rdata = {14'h0, state_reg.home_phase, 7'h0,
          state_reg.record};
        `REG_DIAG_ADDR: state_next.rdata = {18'h0, state_reg.warning, state_reg.error,
          state_reg.diag_sub, state_reg.diag_main};
        `REG_STATUS_ADDR: state_next.rdata = {24'h0, state_reg.seg};
        `REG_MOTION_ADDR: state_next.rdata = {29'h0, stage_enable_o, state_reg.enable,
          fault_cause_i};
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // enable input filter; the acknowledging edge also drops enable
    if (enable_ack_input_i == state_reg.en_filt) begin
      state_next.filt_cnt = 16'h0;
    end else if (state_reg.filt_cnt == 16'(FILTER_CYCLES - 1)) begin
      state_next.filt_cnt = 16'h0;
      state_next.en_filt = enable_ack_input_i;
    end else begin
      state_next.filt_cnt = state_reg.filt_cnt + 16'h1;
    end
    en_fall = state_reg.en_filt && !state_next.en_filt; // RQ21
    if (en_fall) ack = 1'b1; // RQ17
    state_next.enable = state_next.en_filt;

    // error clears only on acknowledge with cause gone; a new fault wins
    if (ack && !fault_cause_i) state_next.error = 1'b0; // RQ20
    if (fault_cause_i || set_err) state_next.error = 1'b1;
    if (!warning_cause_i && state_reg.warning && state_reg.warn_shown >= 2'(`WARN_REPEATS)) begin
      state_next.warning = 1'b0; // RQ18
    end

    // sequencing and blinking
    step_tick = state_reg.step_cnt == 24'(STEP_CYCLES - 1);
    blink_tick = state_reg.blink_cnt == 24'(BLINK_CYCLES - 1);
    state_next.step_cnt = step_tick ? 24'h0 : state_reg.step_cnt + 24'h1;
    state_next.blink_cnt = blink_tick ? 24'h0 : state_reg.blink_cnt + 24'h1;
    if (blink_tick) state_next.blink = !state_reg.blink;
    if (step_tick) begin
      if (state_reg.char_idx + 3'd1 >= char_count) begin
        state_next.char_idx = 3'd0; // RQ2
        if (!state_reg.error && state_reg.warning && state_reg.warn_shown != 2'd3) begin
          state_next.warn_shown = state_reg.warn_shown + 2'd1; // RQ16
        end
      end else begin
        state_next.char_idx = state_reg.char_idx + 3'd1;
      end
    end
    if (state_next.char_idx >= char_count) state_next.char_idx = 3'd0;
    // a freshly reported warning beats a self-clear in the same cycle
    if (set_warn) begin
      state_next.warning = 1'b1;
      state_next.warn_shown = 2'd0;
    end

    // segment image
    rot = 8'(8'h01 << speed_phase_i[2:0] % 3'd6); // RQ10
    if (show_diag) begin
      state_next.seg = {1'b0, cur_seg};
    end else begin
      case (state_reg.mode)
        MODE_BOOT: state_next.seg = state_reg.blink ? `SEG_DOT : `SEG_BLANK; // RQ6
        MODE_SAFE: state_next.seg = state_reg.blink ? {1'b0, cur_seg} : `SEG_BLANK; // RQ8
        MODE_SPEED: state_next.seg = rot | (state_reg.enable ? `SEG_MIDDLE : 8'h00); // RQ11
        default: state_next.seg = {1'b0, cur_seg};
      endcase
    end

    // reset button: one fixed-length processor reset pulse per press
    btn_press = reset_button_i && !state_reg.btn_prev;
    state_next.btn_prev = reset_button_i;
    if (btn_press) begin
      state_next.rst_cnt = 12'(RESET_CYCLES); // RQ19
    end else if (state_reg.rst_cnt != 12'h0) begin
      state_next.rst_cnt = state_reg.rst_cnt - 12'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !state_reg.aw_full;
  assign s_axi_wready = !state_reg.w_full;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign segments_o = state_reg.seg;
  assign run_fault_lamp_green_o = !state_reg.error; // RQ3
  assign run_fault_lamp_red_o = state_reg.error;
  assign enable_lamp_o = state_reg.enable;
  assign fieldbus_lamp_o = state_reg.fieldbus;
  assign stage_enable_o = state_reg.enable && !state_reg.error; // RQ20
  assign processor_reset_o = state_reg.rst_cnt != 12'h0;
endmodule : status_display

// ==== sim/status_display_assertions.sv ====
// assertions on lamps, power stage and processor reset of the status display
module status_display_assertions #(
  parameter int RESET_CYCLES = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic enable_ack_input_i,
  input wire logic fault_cause_i,
  input wire logic run_fault_lamp_green_o,
  input wire logic run_fault_lamp_red_o,
  input wire logic enable_lamp_o,
  input wire logic stage_enable_o,
  input wire logic processor_reset_o
);
  logic [15:0] pulse_reg;
  logic [15:0] pulse_next;
  // length of the running processor reset pulse
  always_comb begin
    pulse_next = processor_reset_o ? pulse_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_reg <= 16'h0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_lamp_pair;
    run_fault_lamp_green_o != run_fault_lamp_red_o;
  endproperty
  a_lamp_pair: assert property (p_lamp_pair) else $error("run lamp colours");
  property p_fault_trips;
    fault_cause_i |-> ##[1:2] (run_fault_lamp_red_o && !stage_enable_o);
  endproperty
  a_fault_trips: assert property (p_fault_trips) else $error("fault not shown");
  property p_hold_fault;
    run_fault_lamp_red_o && fault_cause_i |=> run_fault_lamp_red_o;
  endproperty
  a_hold_fault: assert property (p_hold_fault) else $error("error left early");
  property p_clear_cause;
    $fell(run_fault_lamp_red_o) |-> !$past(fault_cause_i);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("cleared with cause");
  property p_stage_needs;
    stage_enable_o |-> enable_lamp_o && run_fault_lamp_green_o;
  endproperty
  a_stage_needs: assert property (p_stage_needs) else $error("stage on wrongly");
  property p_enable_on;
    enable_ack_input_i [*8] |-> enable_lamp_o;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("enable lamp dark");
  property p_ack_edge;
    $fell(enable_lamp_o) && !fault_cause_i && !$past(fault_cause_i)
      |-> ##[0:3] run_fault_lamp_green_o;
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("edge did not ack");
  property p_pulse_len;
    $fell(processor_reset_o) |-> pulse_reg == 16'(RESET_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length");
endmodule : status_display_assertions
bind status_display status_display_assertions #(.RESET_CYCLES(RESET_CYCLES)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_ack_input_i(enable_ack_input_i),
  .fault_cause_i(fault_cause_i), .run_fault_lamp_green_o(run_fault_lamp_green_o),
  .run_fault_lamp_red_o(run_fault_lamp_red_o), .enable_lamp_o(enable_lamp_o),
  .stage_enable_o(stage_enable_o), .processor_reset_o(processor_reset_o)
);

// ==== sim/operator_host.sv ====
// host model driving the controller enable input with held levels
module operator_host #(
  parameter int HOLD_CYCLES = 6
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level asked for and level driven
  input wire logic want_enable_i,
  output logic enable_ack_input_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int held;
  // a level stays long enough for the input filter before it may change
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_ack_input_o <= 1'h0;
      held <= 0;
    end else if (want_enable_i != enable_ack_input_o && held >= HOLD_CYCLES) begin
      enable_ack_input_o <= want_enable_i;
      held <= 0;
    end else begin
      held <= held + 1;
    end
  end
endmodule : operator_host

// ==== sim/status_display_bench.sv ====
// self-checking bench of the status display
`include "status_display_map.svh"
module status_display_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import status_display_pkg::*;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [11:0] aw_addr = 12'h0;
  logic [11:0] ar_addr = 12'h0;
  logic [31:0] w_data = 32'h0;
  logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0, ar_valid = 1'h0, r_ready = 1'h0;
  logic fault = 1'h0, warn = 1'h0, button = 1'h0, want_en = 1'h1;
  logic [3:0] w_strb = 4'hF;
  logic [3:0] phase = 4'h0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, en_in;
  logic green, red, en_lamp, bus_lamp, stage, proc_rst;
  logic [31:0] r_data;
  resp_type b_resp, r_resp;
  segment_type seg;
  int fail_count = 0;
  int n_tests = 0;
  status_display #(
    .STEP_CYCLES(4), .BLINK_CYCLES(2), .FILTER_CYCLES(2), .RESET_CYCLES(3)
  ) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
    .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .enable_ack_input_i(en_in),
    .reset_button_i(button), .fault_cause_i(fault), .warning_cause_i(warn),
    .speed_phase_i(phase), .segments_o(seg), .run_fault_lamp_green_o(green),
    .run_fault_lamp_red_o(red), .enable_lamp_o(en_lamp), .fieldbus_lamp_o(bus_lamp),
    .stage_enable_o(stage), .processor_reset_o(proc_rst)
  );
  operator_host #(.HOLD_CYCLES(6)) host (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .want_enable_i(want_en), .enable_ack_input_o(en_in)
  );
  always #25 clk_i = ~clk_i;
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic hang();
    fail_count++;
    close_out();
  endtask : hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output resp_type r);
    int n;
    @(posedge clk_i);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'h1;
    w_valid <= 1'h1;
    b_ready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (aw_ready) aw_valid <= 1'h0;
      if (w_ready) w_valid <= 1'h0;
      if (b_valid) break;
    end
    if (n == 40) hang();
    r = b_resp;
    b_ready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output resp_type r);
    int n;
    @(posedge clk_i);
    ar_addr <= a;
    ar_valid <= 1'h1;
    r_ready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (ar_ready) ar_valid <= 1'h0;
      if (r_valid) break;
    end
    if (n == 40) hang();
    d = r_data;
    r = r_resp;
    r_ready <= 1'h0;
  endtask : axi_rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    resp_type r;
    axi_wr(a, d, r);
    chk(32'(r), 32'h0, "write response");
  endtask : wr
  // blanks are dropped and repeats merged, so the step phase does not matter
  task automatic t_show(input segment_type p [4], input int len, input int min_hits);
    segment_type seen [$];
    int hits;
    int k;
    hits = 0;
    repeat (80) begin
      @(posedge clk_i);
      if (seg !== 8'h00 && (seen.size() == 0 || seen[$] !== seg)) seen.push_back(seg);
    end
    for (int i = 0; i + len <= seen.size(); i++) begin
      for (k = 0; k < len && seen[i + k] === p[k]; k++) begin
      end
      if (k == len) hits++;
    end
    chk(32'(hits >= min_hits), 32'h1, "character sequence");
  endtask : t_show
  task automatic t_blink(input mode_type m, input segment_type on);
    int n_on;
    int n_off;
    n_on = 0;
    n_off = 0;
    wr(`REG_MODE_ADDR, 32'(m));
    repeat (15) begin
      @(posedge clk_i);
      if (seg === on) n_on++;
      else if (seg === `SEG_BLANK) n_off++;
    end
    chk(32'(n_on + n_off), 32'hF, "blink pattern");
    chk(32'(n_on > 1 && n_off > 1), 32'h1, "blink toggles");
  endtask : t_blink
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bus();
    logic [31:0] d;
    resp_type r;
    w_strb <= 4'h0;
    wr(`REG_MODE_ADDR, 32'(MODE_FLASH));
    w_strb <= 4'hF;
    axi_rd(`REG_MODE_ADDR, d, r);
    chk(d, 32'(MODE_UNPARAM), "masked lanes kept");
    wr(`REG_CTRL_ADDR, 32'h4);
    axi_rd(`REG_CTRL_ADDR, d, r);
    chk(32'({bus_lamp, d[2]}), 32'h3, "fieldbus lamp on");
    wr(`REG_CTRL_ADDR, 32'h0);
    chk(32'(bus_lamp), 32'h0, "fieldbus lamp off");
    axi_rd(12'h100, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(32'(r), 32'h2, "unmapped read");
    axi_wr(12'h100, 32'h0, r);
    chk(32'(r), 32'h2, "unmapped write");
  endtask : t_bus
  task automatic t_speed();
    segment_type a;
    wr(`REG_MODE_ADDR, 32'(MODE_SPEED));
    repeat (6) @(posedge clk_i);
    a = seg;
    chk(32'(seg[6]), 32'h1, "middle bar with enable");
    phase <= 4'h3;
    repeat (6) @(posedge clk_i);
    chk(32'(seg !== a && seg[5:0] != 6'h0), 32'h1, "outer segments move");
    want_en <= 1'h0;
    repeat (20) @(posedge clk_i);
    chk(32'({seg[6], en_lamp}), 32'h0, "bar and lamp off");
    want_en <= 1'h1;
    repeat (20) @(posedge clk_i);
  endtask : t_speed
  task automatic t_ack();
    for (int m = 0; m < 3; m++) begin
      fault <= 1'h1;
      repeat (3) @(posedge clk_i);
      chk(32'({red, stage}), 32'h2, "fault trips stage");
      if (m == 0) wr(`REG_CTRL_ADDR, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(32'(red), 32'h1, "ack refused with cause");
      fault <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk(32'(red), 32'h1, "error held until ack");
      if (m < 2) wr(`REG_CTRL_ADDR, 32'(1 << m));
      else want_en <= 1'h0;
      repeat (20) @(posedge clk_i);
      chk(32'({green, stage}), (m < 2) ? 32'h3 : 32'h2, "ack clears");
      want_en <= 1'h1;
      repeat (20) @(posedge clk_i);
    end
  endtask : t_ack
  task automatic t_warn();
    logic [31:0] d;
    resp_type r;
    warn <= 1'h1;
    wr(`REG_DIAG_ADDR, 32'h2104);
    t_show('{8'h40, 8'h3F, 8'h66, 8'h06}, 4, 2);
    chk(32'(red), 32'h0, "warning is no error");
    warn <= 1'h0;
    for (int n = 0; n < 30; n++) begin
      axi_rd(`REG_DIAG_ADDR, d, r);
      if (d[13] == 1'h0) break;
    end
    chk(32'(d[13]), 32'h0, "warning clears itself");
  endtask : t_warn
  task automatic t_button();
    int n;
    n = 0;
    button <= 1'h1;
    @(posedge clk_i);
    button <= 1'h0;
    repeat (10) begin
      @(posedge clk_i);
      if (proc_rst === 1'h1) n++;
    end
    chk(32'(n), 32'h3, "processor reset pulse");
  endtask : t_button
  initial begin
    static segment_type digit_seg [3] = '{8'h3F, 8'h06, 8'h5B};
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk(32'(seg), 32'h77, "idle shows A");
    chk(32'({green, red}), 32'h2, "idle lamps");
    t_bus();
    wr(`REG_MODE_ADDR, 32'(MODE_FLASH));
    repeat (3) @(posedge clk_i);
    chk(32'(seg), 32'h71, "flash shows F");
    wr(`REG_MODE_ADDR, 32'(MODE_CARD_LOAD));
    repeat (3) @(posedge clk_i);
    chk(32'(seg), 32'h5E, "card load shows d");
    wr(`REG_MODE_ADDR, 32'(MODE_TORQUE));
    repeat (3) @(posedge clk_i);
    chk(32'(seg), 32'h06, "torque shows I");
    t_blink(MODE_BOOT, `SEG_DOT);
    t_blink(MODE_SAFE, 8'h76);
    wr(`REG_MODE_ADDR, 32'(MODE_IDENTIFY));
    t_show('{8'h76, 8'h79, 8'h38, 8'h3F}, 4, 1);
    wr(`REG_RECORD_ADDR, 32'h0);
    wr(`REG_MODE_ADDR, 32'(MODE_POSITION));
    t_show('{8'h73, 8'h3F, 8'h73, 8'h00}, 3, 1);
    wr(`REG_RECORD_ADDR, 32'h7D);
    t_show('{8'h73, 8'h06, 8'h5B, 8'h6D}, 4, 1);
    wr(`REG_RECORD_ADDR, 32'h103);
    t_show('{8'h73, 8'h5B, 8'h6D, 8'h6F}, 4, 1);
    wr(`REG_MODE_ADDR, 32'(MODE_HOMING));
    for (int ph = 0; ph < 3; ph++) begin
      wr(`REG_RECORD_ADDR, 32'(ph) << 16);
      t_show('{8'h73, 8'h76, digit_seg[ph], 8'h00}, 3, 1);
    end
    t_speed();
    wr(`REG_DIAG_ADDR, 32'h1305);
    t_show('{8'h79, 8'h3F, 8'h6D, 8'h4F}, 4, 1);
    t_ack();
    t_warn();
    t_button();
    close_out();
  end
endmodule : status_display_bench
